// ==== inc/pfx_pkg.sv ====
package pfx_pkg;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_BITBR = 5'h01,
    OP_JUMP = 5'h02,
    OP_SHORT_CALL = 5'h03,
    OP_LONG_CALL = 5'h04,
    OP_JUMP_CALL = 5'h05,
    OP_SUB_RET = 5'h06,
    OP_SOFT_TRAP = 5'h07,
    OP_TRAP_RET = 5'h08,
    OP_ADD_B = 5'h09,
    OP_ADD_D = 5'h0a,
    OP_ADD_E = 5'h0b,
    OP_ADD_IMM = 5'h0c,
    OP_STK_TO_IDX = 5'h0d,
    OP_IDX_TO_STK = 5'h0e,
    OP_IDX_CMP = 5'h0f,
    OP_IDX_MOVE = 5'h10,
    OP_XCHG_D = 5'h11,
    OP_XCHG_E = 5'h12
  } pfx_op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_READ = 3'h1,
    S_PUSH_PC = 3'h2,
    S_PUSH_CCR = 3'h3,
    S_PULL_CCR = 3'h4,
    S_PULL_PC = 3'h5,
    S_VECTOR = 3'h6
  } pfx_state_t;

  typedef enum logic [1:0] {
    AM_SHORT_IDX = 2'h0,
    AM_LONG_IDX = 2'h1,
    AM_EXTENDED = 2'h2
  } pfx_amode_t;

  typedef struct packed {
    logic valid;
    logic isSet;
    pfx_amode_t mode;
    logic [1:0] idx;
  } pfx_bitbr_t;

endpackage

// ==== inc/pfx_regs.svh ====
// How it works
// - Bit branch reads byte at 20-bit address.
// - Satisfied test adds signed offset to PC.
// - PC overflow or underflow carries into page.
// - Fourteen bit-branch opcodes map to seven modes.
// - Branch offsets lose bit 0 always.
// - Offsets add to instruction address plus six, plus four for short call.
// - Jump loads full 20-bit page and PC.
// - Calls push PC, then flags, step two.
// - Short call stacks PC minus two.
// - Return pulls page, PC, then subtracts two.
// - Soft trap pushes PC+2, vectors via 000C.
// - Trap return pulls flags, PC, subtracts six.
// - Hardware interrupt stacks pipelined PC unchanged.
// - Interrupt waits for current instruction end.
// - B zero-extends, D and E sign-extend.
// - Immediate sign-extends, adds to 20 bits.
// - Index compare sets flags, register kept.
`ifndef PFX_REGS_SVH
`define PFX_REGS_SVH

// -----------------------------------------------------------------
// Address arithmetic
// -----------------------------------------------------------------
`define PFX_PIPE_ADJ 20'h00006
`define PFX_CALL_ADJ 20'h00002
`define PFX_TRAP_ADJ 20'h00002
`define PFX_TRAP_RET_ADJ 20'h00006
`define PFX_STACK_STEP 20'h00002
`define PFX_TRAP_VEC_ADDR 20'h0000c

// -----------------------------------------------------------------
// Reset values and flag positions within flagsHi
// -----------------------------------------------------------------
`define PFX_RESET_PC 20'h00000
`define PFX_RESET_STACK 20'h00000
`define PFX_RESET_CCR 12'h000
`define PFX_FLAG_N 7
`define PFX_FLAG_Z 6
`define PFX_FLAG_V 5
`define PFX_FLAG_C 4

// -----------------------------------------------------------------
// Bit-condition branch opcodes
// -----------------------------------------------------------------
`define PFX_BC_SIDX_X 8'hcb
`define PFX_BC_SIDX_Y 8'hdb
`define PFX_BC_SIDX_Z 8'heb
`define PFX_BC_LIDX_X 8'h0a
`define PFX_BC_LIDX_Y 8'h1a
`define PFX_BC_LIDX_Z 8'h2a
`define PFX_BC_XADR 8'h3a
`define PFX_BS_SIDX_X 8'h8b
`define PFX_BS_SIDX_Y 8'h9b
`define PFX_BS_SIDX_Z 8'hab
`define PFX_BS_LIDX_X 8'h0b
`define PFX_BS_LIDX_Y 8'h1b
`define PFX_BS_LIDX_Z 8'h2b
`define PFX_BS_XADR 8'h3b

`endif

// ==== rtl/pfx_flow_exec.sv ====
`timescale 1ns/1ps
`include "pfx_regs.svh"
module pfx_flow_exec
  import pfx_pkg::*;
(
  input wire logic clk_sys, // 10 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic start, // Execute request, taken while idle
  input wire pfx_op_t opKind, // Operation class
  input wire logic [7:0] opcode, // Bit-branch opcode byte
  input wire logic [19:0] instrAddr, // Address of this instruction
  input wire logic [15:0] eaOff, // Indexed operand offset
  input wire logic [19:0] extAddr, // Extended address or jump target
  input wire logic [7:0] mask, // Bit-branch mask
  input wire logic [15:0] brOff, // Relative offset
  input wire logic brLong, // Offset is 16-bit
  input wire logic [15:0] immVal, // Immediate for index add
  input wire logic immLong, // Immediate is 16-bit
  input wire logic [1:0] selIdx, // Index select 0 X, 1 Y, 2 Z
  input wire logic [1:0] selDst, // Destination index for moves
  input wire logic [15:0] accD, // Accumulator D, B is low byte
  input wire logic [15:0] accE, // Accumulator E
  input wire logic irqReq, // Pending interrupt, level
  input wire logic [7:0] irqVector, // Interrupt vector number
  input wire logic memAck, // Memory completes access
  input wire logic [15:0] memRdata, // Memory read data
  output logic busy, // Sequence in progress
  output logic done, // Instruction finished, pulse
  output logic irqAck, // Interrupt taken, pulse
  output logic [3:0] pgExt, // Program page extension
  output logic [15:0] pc, // Program counter
  output logic [3:0] stkExt, // Stack page extension
  output logic [15:0] sp, // Stack pointer
  output logic [2:0][3:0] idxK, // Index page extensions
  output logic [2:0][15:0] idxVal, // Index registers
  output logic [11:0] flagsHi, // Flag bits above the page field
  output logic [15:0] accOut, // Exchange result for accumulator
  output logic accWrD, // Write accOut to D, pulse
  output logic accWrE, // Write accOut to E, pulse
  output logic memReq, // Memory request
  output logic memWe, // Write access
  output logic memByte, // Byte access
  output logic [19:0] memAddr, // Memory address
  output logic [15:0] memWdata // Write data
);

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [19:0] sext8(input logic [7:0] v);
    return {{12{v[7]}}, v};
  endfunction
  function automatic logic [19:0] sext16(input logic [15:0] v);
    return {{4{v[15]}}, v};
  endfunction
  function automatic logic [19:0] brOffset(input logic [15:0] v, input logic isLong);
    return (isLong ? sext16(v) : sext8(v[7:0])) & 20'hffffe;
  endfunction
  function automatic logic bitTest(input logic [7:0] m, input logic [7:0] k, input logic s);
    return s ? ((~m & k) == 8'h00) : ((m & k) == 8'h00);
  endfunction
  function automatic pfx_bitbr_t decodeBitBr(input logic [7:0] op);
    pfx_bitbr_t d;
    d = '{valid: 1'b1, isSet: 1'b0, mode: AM_SHORT_IDX, idx: 2'h0};
    unique case (op)
      `PFX_BC_SIDX_X, `PFX_BS_SIDX_X: d.idx = 2'h0;
      `PFX_BC_SIDX_Y, `PFX_BS_SIDX_Y: d.idx = 2'h1;
      `PFX_BC_SIDX_Z, `PFX_BS_SIDX_Z: d.idx = 2'h2;
      `PFX_BC_LIDX_X, `PFX_BS_LIDX_X: d.mode = AM_LONG_IDX;
      `PFX_BC_LIDX_Y, `PFX_BS_LIDX_Y: begin d.mode = AM_LONG_IDX; d.idx = 2'h1; end
      `PFX_BC_LIDX_Z, `PFX_BS_LIDX_Z: begin d.mode = AM_LONG_IDX; d.idx = 2'h2; end
      `PFX_BC_XADR, `PFX_BS_XADR: d.mode = AM_EXTENDED;
      default: d.valid = 1'b0;
    endcase
    d.isSet = op inside {`PFX_BS_SIDX_X, `PFX_BS_SIDX_Y, `PFX_BS_SIDX_Z, `PFX_BS_LIDX_X,
        `PFX_BS_LIDX_Y, `PFX_BS_LIDX_Z, `PFX_BS_XADR};
    return d;
  endfunction
  function automatic logic [1:0] clampSel(input logic [1:0] s);
    return (s == 2'h3) ? 2'h0 : s;
  endfunction

  // -----------------------------------------------------------------
  // Decode and address arithmetic
  // -----------------------------------------------------------------
  pfx_state_t state;
  pfx_state_t nextState;
  pfx_op_t kind;
  pfx_bitbr_t bb;
  logic trapMode, bbSet, accept, irqTake, xfer;
  logic [7:0] maskReg;
  logic [3:0] pulledK;
  logic [1:0] src, dst, srcReg;
  logic [19:0] pipe, stackAddr, idxAddr, bbBase, eaAddr, retCalc, retReg;
  logic [19:0] tgtCalc, tgtReg, vecAddr, nextStack, off;
  assign bb = decodeBitBr(opcode);
  assign src = clampSel(selIdx);
  assign dst = clampSel(selDst);
  assign irqTake = (state == S_IDLE) && irqReq;
  assign accept = (state == S_IDLE) && !irqReq && start;
  assign xfer = memReq && memAck;
  assign pipe = instrAddr + `PFX_PIPE_ADJ;
  assign stackAddr = {stkExt, sp};
  assign idxAddr = {idxK[src], idxVal[src]};
  assign bbBase = {idxK[bb.idx], idxVal[bb.idx]};
  assign off = brOffset(brOff, brLong);
  always_comb begin
    unique case (bb.mode)
      AM_SHORT_IDX: eaAddr = bbBase + {12'h000, eaOff[7:0]};
      AM_LONG_IDX: eaAddr = bbBase + sext16(eaOff);
      default: eaAddr = extAddr;
    endcase
    if (opKind == OP_IDX_CMP)
      eaAddr = extAddr;
  end
  always_comb begin
    retCalc = pipe;
    if (!irqTake && opKind == OP_SHORT_CALL)
      retCalc = pipe - `PFX_CALL_ADJ;
    else if (!irqTake && opKind == OP_SOFT_TRAP)
      retCalc = pipe + `PFX_TRAP_ADJ;
  end
  always_comb begin
    unique case (opKind)
      OP_SHORT_CALL: tgtCalc = pipe - `PFX_CALL_ADJ + off;
      OP_JUMP_CALL: tgtCalc = extAddr;
      default: tgtCalc = pipe + off;
    endcase
  end
  always_comb begin
    nextStack = stackAddr;
    if (xfer && (state == S_PUSH_PC || state == S_PUSH_CCR))
      nextStack = stackAddr - `PFX_STACK_STEP;
    else if (xfer && (state == S_PULL_CCR || state == S_PULL_PC))
      nextStack = stackAddr + `PFX_STACK_STEP;
  end
  always_comb begin
    nextState = state;
    unique case (state)
      S_IDLE: begin
        if (irqTake)
          nextState = S_PUSH_PC;
        else if (accept) begin
          if ((opKind == OP_BITBR && bb.valid) || opKind == OP_IDX_CMP)
            nextState = S_READ;
          else if (opKind inside {OP_SHORT_CALL, OP_LONG_CALL, OP_JUMP_CALL, OP_SOFT_TRAP})
            nextState = S_PUSH_PC;
          else if (opKind inside {OP_SUB_RET, OP_TRAP_RET})
            nextState = S_PULL_CCR;
        end
      end
      S_READ: if (xfer) nextState = S_IDLE;
      S_PUSH_PC: if (xfer) nextState = S_PUSH_CCR;
      S_PUSH_CCR: if (xfer) nextState = trapMode ? S_VECTOR : S_IDLE;
      S_PULL_CCR: if (xfer) nextState = S_PULL_PC;
      S_PULL_PC: if (xfer) nextState = S_IDLE;
      S_VECTOR: if (xfer) nextState = S_IDLE;
      default: nextState = S_IDLE;
    endcase
  end

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      kind <= OP_NONE;
      trapMode <= 1'b0;
      bbSet <= 1'b0;
      maskReg <= 8'h00;
      srcReg <= 2'h0;
      retReg <= 20'h00000;
      tgtReg <= 20'h00000;
      vecAddr <= 20'h00000;
      busy <= 1'b0;
      done <= 1'b0;
      irqAck <= 1'b0;
    end else begin
      state <= nextState;
      busy <= nextState != S_IDLE;
      done <= nextState == S_IDLE && (state != S_IDLE || accept);
      irqAck <= irqTake;
      if (irqTake) begin
        kind <= OP_NONE;
        trapMode <= 1'b1;
        retReg <= retCalc;
        vecAddr <= {11'h000, irqVector, 1'b0};
      end else if (accept) begin
        kind <= opKind;
        trapMode <= opKind == OP_SOFT_TRAP;
        bbSet <= bb.isSet;
        maskReg <= mask;
        srcReg <= src;
        retReg <= retCalc;
        tgtReg <= tgtCalc;
        vecAddr <= `PFX_TRAP_VEC_ADDR;
      end
    end
  end

  // -----------------------------------------------------------------
  // Memory port
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      memReq <= 1'b0;
      memWe <= 1'b0;
      memByte <= 1'b0;
      memAddr <= 20'h00000;
      memWdata <= 16'h0000;
    end else begin
      memReq <= nextState != S_IDLE;
      memWe <= nextState == S_PUSH_PC || nextState == S_PUSH_CCR;
      memByte <= nextState == S_READ && (state == S_IDLE ? opKind : kind) == OP_BITBR;
      unique case (nextState)
        S_READ: memAddr <= eaAddr;
        S_PUSH_PC: begin
          memAddr <= nextStack;
          memWdata <= retCalc[15:0];
        end
        S_PUSH_CCR: begin
          memAddr <= nextStack;
          memWdata <= {flagsHi, retReg[19:16]};
        end
        S_PULL_CCR, S_PULL_PC: memAddr <= nextStack + `PFX_STACK_STEP;
        S_VECTOR: memAddr <= vecAddr;
        default: memAddr <= memAddr;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Program page and counter
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {pgExt, pc} <= `PFX_RESET_PC;
      pulledK <= 4'h0;
    end else if (accept) begin
      {pgExt, pc} <= (opKind == OP_JUMP) ? extAddr : pipe;
    end else if (xfer) begin
      unique case (state)
        S_READ: if (kind == OP_BITBR && bitTest(memRdata[7:0], maskReg, bbSet))
          {pgExt, pc} <= tgtReg;
        S_PUSH_CCR: if (!trapMode)
          {pgExt, pc} <= tgtReg;
        S_VECTOR: {pgExt, pc} <= {4'h0, memRdata};
        S_PULL_CCR: pulledK <= memRdata[3:0];
        S_PULL_PC: {pgExt, pc} <= {pulledK, memRdata}
            - ((kind == OP_TRAP_RET) ? `PFX_TRAP_RET_ADJ : `PFX_CALL_ADJ);
        default: pulledK <= pulledK;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Stack pointer
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      {stkExt, sp} <= `PFX_RESET_STACK;
    else if (accept && opKind == OP_IDX_TO_STK)
      {stkExt, sp} <= idxAddr - `PFX_STACK_STEP;
    else
      {stkExt, sp} <= nextStack;
  end

  // -----------------------------------------------------------------
  // Index registers and exchanges
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idxK <= '0;
      idxVal <= '0;
      accOut <= 16'h0000;
      accWrD <= 1'b0;
      accWrE <= 1'b0;
    end else begin
      accWrD <= accept && opKind == OP_XCHG_D;
      accWrE <= accept && opKind == OP_XCHG_E;
      if (accept) begin
        unique case (opKind)
          OP_ADD_B: {idxK[src], idxVal[src]} <= idxAddr + {12'h000, accD[7:0]};
          OP_ADD_D: {idxK[src], idxVal[src]} <= idxAddr + sext16(accD);
          OP_ADD_E: {idxK[src], idxVal[src]} <= idxAddr + sext16(accE);
          OP_ADD_IMM: {idxK[src], idxVal[src]} <= idxAddr
              + (immLong ? sext16(immVal) : sext8(immVal[7:0]));
          OP_STK_TO_IDX: {idxK[src], idxVal[src]} <= stackAddr + `PFX_STACK_STEP;
          OP_IDX_MOVE: {idxK[dst], idxVal[dst]} <= idxAddr;
          OP_XCHG_D: begin
            idxVal[src] <= accD;
            accOut <= idxVal[src];
          end
          OP_XCHG_E: begin
            idxVal[src] <= accE;
            accOut <= idxVal[src];
          end
          default: accOut <= accOut;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Condition flags
  // -----------------------------------------------------------------
  logic [15:0] cmpA;
  logic [16:0] cmpDiff;
  assign cmpA = idxVal[srcReg];
  assign cmpDiff = {1'b0, cmpA} - {1'b0, memRdata};
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      flagsHi <= `PFX_RESET_CCR;
    else if (xfer && state == S_READ && kind == OP_IDX_CMP) begin
      flagsHi[`PFX_FLAG_N] <= cmpDiff[15];
      flagsHi[`PFX_FLAG_Z] <= cmpDiff[15:0] == 16'h0000;
      flagsHi[`PFX_FLAG_V] <= (cmpA[15] ^ memRdata[15]) & (cmpDiff[15] ^ cmpA[15]);
      flagsHi[`PFX_FLAG_C] <= cmpDiff[16];
    end else if (xfer && state == S_PULL_CCR && kind == OP_TRAP_RET)
      flagsHi <= memRdata[15:4];
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  pushStep_a: assert property ((state == S_PUSH_PC && xfer) |=>
      {stkExt, sp} == 20'($past(stackAddr) - 20'h00002) && state == S_PUSH_CCR)
    else $error("push did not step stack by two");
  pushOrder_a: assert property ((state == S_PUSH_CCR && memReq) |->
      memWe && memAddr == stackAddr && memWdata[3:0] == retReg[19:16])
    else $error("flag push wrong address or page");
  jumpLoad_a: assert property ((accept && opKind == OP_JUMP) |=>
      {pgExt, pc} == $past(extAddr) && done)
    else $error("jump target not loaded");
  bitTaken_a: assert property ((state == S_READ && xfer && kind == OP_BITBR
      && bitTest(memRdata[7:0], maskReg, bbSet)) |=> {pgExt, pc} == $past(tgtReg))
    else $error("bit branch not taken");
  longOff_a: assert property ((accept && opKind == OP_LONG_CALL) |=>
      tgtReg == 20'($past(instrAddr) + 20'h00006 + {$past(off[19:1]), 1'b0}))
    else $error("branch target arithmetic wrong");
  shortCall_a: assert property ((accept && opKind == OP_SHORT_CALL) |=>
      retReg == 20'($past(instrAddr) + 20'h00004))
    else $error("short call return value wrong");
  trapVec_a: assert property ((state == S_PUSH_CCR && xfer && trapMode
      && kind == OP_SOFT_TRAP) |=> state == S_VECTOR && memAddr == 20'h0000c && !memWe)
    else $error("soft trap vector fetch wrong");
  subRet_a: assert property ((state == S_PULL_PC && xfer && kind == OP_SUB_RET) |=>
      {pgExt, pc} == 20'({$past(pulledK), $past(memRdata)} - 20'h00002))
    else $error("return adjust wrong");
  trapRet_a: assert property ((state == S_PULL_PC && xfer && kind == OP_TRAP_RET) |=>
      {pgExt, pc} == 20'({$past(pulledK), $past(memRdata)} - 20'h00006))
    else $error("trap return adjust wrong");
  irqWait_a: assert property (irqAck |-> $past(state) == S_IDLE
      && state == S_PUSH_PC && retReg == 20'($past(instrAddr) + 20'h00006))
    else $error("interrupt taken mid instruction");
  stkIdx_a: assert property ((accept && opKind == OP_STK_TO_IDX) |=>
      {idxK[$past(src)], idxVal[$past(src)]} == 20'($past(stackAddr) + 20'h00002))
    else $error("stack to index copy wrong");
  cmpKeep_a: assert property ((state == S_READ && kind == OP_IDX_CMP) |=>
      $stable(idxVal) && $stable(idxK))
    else $error("compare changed index");
  callCov_c: cover property ((accept && opKind == OP_JUMP_CALL) ##[1:20] done);
  trapCov_c: cover property ((state == S_VECTOR && xfer) ##1 done);
  bitCov_c: cover property ((state == S_READ && xfer && kind == OP_BITBR) ##1 done);
  irqCov_c: cover property (irqAck ##[1:20] done);
endmodule // pfx_flow_exec

// ==== sim/pfx_mem_model.sv ====
`timescale 1ns/1ps
module pfx_mem_model (
  input wire logic clk_sys, // System clock
  input wire logic slow, // Adds three wait states
  input wire logic memReq, // Access request
  input wire logic memWe, // Write access
  input wire logic memByte, // Byte access
  input wire logic [19:0] memAddr, // Access address
  input wire logic [15:0] memWdata, // Write data
  output logic memAck, // Access complete
  output logic [15:0] memRdata // Read data
);
  logic [7:0] mem [logic [19:0]];
  logic [1:0] waitCnt;

  // Unwritten bytes read as a fixed pattern, so a wrong address shows
  function automatic logic [7:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'h5a;
  endfunction

  initial begin
    memAck = 1'b0;
    memRdata = 16'h0000;
    waitCnt = 2'h0;
  end

  always @(posedge clk_sys) begin
    if (memReq && memAck) begin
      memAck <= 1'b0;
      waitCnt <= 2'h0;
      memRdata <= ~memRdata;
      if (memWe) begin
        mem[memAddr] = memWdata[15:8];
        mem[memAddr + 20'h1] = memWdata[7:0];
      end
    end else if (memReq && waitCnt >= (slow ? 2'h3 : 2'h0)) begin
      memAck <= 1'b1;
      memRdata <= memByte ? {~rd(memAddr), rd(memAddr)} : {rd(memAddr), rd(memAddr + 20'h1)};
    end else begin
      // Bus not answered: data keeps changing
      memRdata <= ~memRdata;
      if (memReq) begin
        waitCnt <= waitCnt + 2'h1;
      end
    end
  end
endmodule // pfx_mem_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import pfx_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, start = 1'b0, brLong = 1'b0, immLong = 1'b0;
  logic irqReq = 1'b0, memAck, busy, done, irqAck, accWrD, accWrE, memReq, memWe, memByte;
  logic slow = 1'b0;
  pfx_op_t opKind = OP_NONE;
  logic [7:0] opcode = 8'h00, mask = 8'h00, irqVector = 8'h00;
  logic [19:0] instrAddr = 20'h0, extAddr = 20'h0, memAddr;
  logic [15:0] eaOff = 16'h0, brOff = 16'h0, immVal = 16'h0, accD = 16'h0, accE = 16'h0;
  logic [15:0] memRdata, pc, sp, accOut, memWdata;
  logic [1:0] selIdx = 2'h0;
  logic [3:0] pgExt, stkExt;
  logic [2:0][3:0] idxK;
  logic [2:0][15:0] idxVal;
  logic [11:0] flagsHi;
  int n_errors = 0, samples_checked = 0;

  always #50 clk_sys = ~clk_sys;

  pfx_flow_exec i_pfx_flow_exec (.clk_sys(clk_sys), .rst(rst), .start(start), .opKind(opKind),
    .opcode(opcode), .instrAddr(instrAddr), .eaOff(eaOff), .extAddr(extAddr), .mask(mask),
    .brOff(brOff), .brLong(brLong), .immVal(immVal), .immLong(immLong), .selIdx(selIdx),
    .selDst(2'h1), .accD(accD), .accE(accE), .irqReq(irqReq), .irqVector(irqVector),
    .memAck(memAck), .memRdata(memRdata), .busy(busy), .done(done), .irqAck(irqAck),
    .pgExt(pgExt), .pc(pc), .stkExt(stkExt), .sp(sp), .idxK(idxK), .idxVal(idxVal),
    .flagsHi(flagsHi), .accOut(accOut),
    .accWrD(accWrD), .accWrE(accWrE), .memReq(memReq), .memWe(memWe), .memByte(memByte),
    .memAddr(memAddr), .memWdata(memWdata));

  pfx_mem_model i_pfx_mem_model (.clk_sys(clk_sys), .slow(slow), .memReq(memReq),
    .memWe(memWe), .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata),
    .memAck(memAck), .memRdata(memRdata));

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] word(input logic [19:0] a);
    return {i_pfx_mem_model.rd(a), i_pfx_mem_model.rd(a + 20'h1)};
  endfunction

  // Presents one request at a falling edge and waits for its done pulse
  task automatic go(input pfx_op_t k);
    int n;
    n = 0;
    opKind = k;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    chk({19'h0, done}, 20'h1);
  endtask

  task automatic t_jump();
    extAddr = 20'h51230;
    go(OP_JUMP);
    chk({pgExt, pc}, 20'h51230);
    $display("test jump finished");
  endtask

  task automatic t_bitbr();
    logic [7:0] ops [14] = '{8'hcb, 8'hdb, 8'heb, 8'h0a, 8'h1a, 8'h2a, 8'h3a,
                             8'h8b, 8'h9b, 8'hab, 8'h0b, 8'h1b, 8'h2b, 8'h3b};
    logic [19:0] off20;
    i_pfx_mem_model.mem[20'h00040] = 8'h0f;
    eaOff = 16'h0040;
    extAddr = 20'h00040;
    for (int i = 0; i < 16; i++) begin
      slow = i[1];
      opcode = (i < 14) ? ops[i] : (i == 14 ? 8'h3a : 8'h3b);
      mask = (i < 7) ? 8'hf0 : (i < 14 ? 8'h0f : 8'hff);
      instrAddr = (i < 7) ? 20'h0fffc : 20'h00002;
      brLong = i[0];
      brOff = (i < 7) ? (brLong ? 16'h7fff : 16'h0011) : (brLong ? 16'h8000 : 16'h0080);
      off20 = brLong ? {{4{brOff[15]}}, brOff[15:1], 1'b0} : {{12{brOff[7]}}, brOff[7:1], 1'b0};
      go(OP_BITBR);
      if (i < 14) chk({pgExt, pc}, instrAddr + 20'h6 + off20);
      else chk({pgExt, pc}, instrAddr + 20'h6);
    end
    slow = 1'b0;
    $display("test bit branch finished");
  endtask

  task automatic call_ret(input pfx_op_t k, input logic [15:0] stk, input logic [19:0] tgt,
                          input logic [19:0] ret);
    instrAddr = 20'h21000;
    go(k);
    chk({pgExt, pc}, tgt);
    chk({4'h0, word(20'h00000)}, {4'h0, stk});
    chk({4'h0, word(20'hffffe)}, {4'h0, flagsHi, 4'h2});
    chk({stkExt, sp}, 20'hffffc);
    go(OP_SUB_RET);
    chk({pgExt, pc}, ret);
    chk({stkExt, sp}, 20'h00000);
  endtask

  task automatic t_calls();
    extAddr = 20'h30400;
    call_ret(OP_JUMP_CALL, 16'h1006, 20'h30400, 20'h21004);
    brLong = 1'b0;
    brOff = 16'h0020;
    call_ret(OP_SHORT_CALL, 16'h1004, 20'h21024, 20'h21002);
    brLong = 1'b1;
    brOff = 16'h0100;
    call_ret(OP_LONG_CALL, 16'h1006, 20'h21106, 20'h21004);
    $display("test calls finished");
  endtask

  task automatic t_traps();
    int n;
    i_pfx_mem_model.mem[20'h0000c] = 8'h40;
    i_pfx_mem_model.mem[20'h0000d] = 8'h00;
    i_pfx_mem_model.mem[20'h00020] = 8'h12;
    i_pfx_mem_model.mem[20'h00021] = 8'h34;
    instrAddr = 20'h35000;
    go(OP_SOFT_TRAP);
    chk({pgExt, pc}, 20'h04000);
    chk({4'h0, word(20'h00000)}, 20'h05008);
    go(OP_TRAP_RET);
    chk({pgExt, pc}, 20'h35002);
    chk({stkExt, sp}, 20'h00000);
    // A jump offered with the interrupt must be refused
    instrAddr = 20'h47000;
    irqVector = 8'h10;
    extAddr = 20'h11111;
    opKind = OP_JUMP;
    irqReq = 1'b1;
    start = 1'b1;
    n = 0;
    while (irqAck !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    irqReq = 1'b0;
    start = 1'b0;
    chk({19'h0, irqAck}, 20'h1);
    go(OP_NONE);
    chk({pgExt, pc}, 20'h01234);
    chk({4'h0, word(20'h00000)}, 20'h07006);
    go(OP_TRAP_RET);
    chk({pgExt, pc}, 20'h47000);
    $display("test traps finished");
  endtask

  task automatic t_index();
    pfx_op_t ks [6] = '{OP_STK_TO_IDX, OP_ADD_B, OP_ADD_D, OP_ADD_E, OP_ADD_IMM, OP_ADD_IMM};
    logic [19:0] ex [6] = '{20'h00002, 20'h00082, 20'h00002, 20'hf8002, 20'hf8000, 20'hf00fe};
    accD = 16'hff80;
    accE = 16'h8000;
    immVal = 16'h80fe;
    for (int i = 0; i < 6; i++) begin
      immLong = (i == 5);
      go(ks[i]);
      chk({idxK[0], idxVal[0]}, ex[i]);
    end
    go(OP_IDX_TO_STK);
    chk({stkExt, sp}, 20'hf00fc);
    i_pfx_mem_model.mem[20'h00080] = 8'h00;
    i_pfx_mem_model.mem[20'h00081] = 8'hfe;
    extAddr = 20'h00080;
    go(OP_IDX_CMP);
    chk({19'h0, flagsHi[6]}, 20'h1);
    chk({idxK[0], idxVal[0]}, 20'hf00fe);
    go(OP_XCHG_D);
    chk({4'h0, accOut}, 20'h000fe);
    chk({19'h0, accWrD}, 20'h1);
    go(OP_IDX_MOVE);
    chk({idxK[1], idxVal[1]}, 20'hfff80);
    $display("test index finished");
  endtask

  task automatic end_of_test();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    chk({pgExt, pc}, 20'h0);
    chk({stkExt, sp}, 20'h0);
    t_jump();
    t_bitbr();
    t_calls();
    t_traps();
    t_index();
    end_of_test();
  end

  initial begin
    #2000000;
    n_errors++;
    end_of_test();
  end
endmodule // testbench
